//--- hw/pmms_top.sv
// Contract
// - host sees 256 bytes: lower 00h-7Fh, upper 80h-FFh.
// - lower 128 bytes always reachable regardless of page or bank.
// - upper region maps exactly one selected 128-byte page.
// - bank selection picks which instance of a multi-instance page shows.
// - lower region and page 00h always implemented.
// - pages 01h, 02h and banks 0 and 1 of 10h, 11h implemented.
// - banks of 10h-1Fh each cover four lanes; bank 1 covers lanes 5-8.
// - flags and monitors live in lower region, readable without paging.
// - low recovered reset input resets the module.
// - module signals interrupt by driving its interrupt indication high.
// - combined reset/interrupt line carries both directions at once.
// - low recovered low-power input puts module in low-power mode.
// - module shows presence with fixed pull-down on combined line.
// - host reaches management memory only over two-wire serial interface.
// - single serial device address; paging extends the space.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`include "pmms_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module pmms_top
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        scl_in,
  output var  logic        scl_out,
  output var  logic        scl_oe,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe,
  input  wire logic        module_side_reset_n,
  input  wire logic        module_side_lowpower_n,
  output var  logic        irq_reset_combined_line_drive,
  output var  logic        lowpower_present_combined_line_pulldown,
  output var  logic        lowpower_mode,
  output var  logic        module_reset_active,
  output var  logic        irq
);

  logic [7:0]              mem [0:`PMMS_MEM_DEPTH-1];
  pmms_pkg::pmms_state_t   state_ff;
  logic [7:0]              sh_ff;
  logic [3:0]              cnt_ff;
  logic                    rw_ff;
  logic                    more_ff;
  logic [7:0]              ofs_ff;
  logic [7:0]              page_sel_ff;
  logic [7:0]              bank_sel_ff;
  logic                    scl_q_ff;
  logic                    sda_q_ff;
  logic                    sda_oe_ff;
  logic [6:0]              dev_addr_ff;
  logic [`PMMS_EV_W-1:0]   status_ff;
  logic [`PMMS_EV_W-1:0]   mask_ff;
  logic [9:0]              mem_addr_ff;
  logic                    pend_ff;
  logic [9:0]              pend_idx_ff;
  logic [7:0]              pend_data_ff;
  logic                    rst_q_ff;
  logic                    lowpower_ff;
  logic [31:0]             prdata_ff;
  logic                    pready_ff;
  logic                    pslverr_ff;
  logic                    irq_ff;
  logic                    line_drive_ff;
  logic                    pulldown_ff;
  logic                    mod_rst;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_det;
  logic                    stop_det;
  logic [10:0]             wmap;
  logic [7:0]              rd_byte;
  logic                    i2c_we;
  logic                    sel_we;
  logic                    apb_acc;
  logic                    apb_wr;
  logic [`PMMS_EV_W-1:0]   ev_set;
  logic [`PMMS_EV_W-1:0]   ev_clr;
  logic [31:0]             rd_mux;
  logic                    rd_hit;

  // {valid, slot, offset}: invalid when an upper-region offset selects an absent page/bank
  function automatic logic [10:0] pmms_map
  (
    input logic [7:0] ofs,
    input logic [7:0] pg,
    input logic [7:0] bk
  );
    logic [2:0] slot;
    logic       ok;
    slot = `PMMS_SLOT_LOWER;
    ok   = 1'b1;
    if (ofs[`PMMS_UPPER_BIT])
    begin
      case (pg)
        `PMMS_PAGE_00: slot = `PMMS_SLOT_P00;
        `PMMS_PAGE_01: slot = `PMMS_SLOT_P01;
        `PMMS_PAGE_02: slot = `PMMS_SLOT_P02;
        `PMMS_PAGE_10: slot = bk[0] ? `PMMS_SLOT_P10_B1 : `PMMS_SLOT_P10_B0;
        `PMMS_PAGE_11: slot = bk[0] ? `PMMS_SLOT_P11_B1 : `PMMS_SLOT_P11_B0;
        default:       ok = 1'b0;
      endcase
      // only banks 0 and 1 exist, and only for paged lane pages
      if ((pg == `PMMS_PAGE_10 || pg == `PMMS_PAGE_11) && bk[7:1] != 7'h00)
      begin
        ok = 1'b0;
      end
    end
    pmms_map = {ok, slot, ofs[6:0]};
  endfunction

  assign mod_rst   = ~module_side_reset_n;
  assign scl_rise  = ~scl_q_ff & scl_in;
  assign scl_fall  = scl_q_ff & ~scl_in;
  assign start_det = scl_q_ff & scl_in & sda_q_ff & ~sda_in;
  assign stop_det  = scl_q_ff & scl_in & ~sda_q_ff & sda_in;

  assign wmap = pmms_map(ofs_ff, page_sel_ff, bank_sel_ff);

  always_comb
  begin
    rd_byte = `PMMS_UNMAPPED_DATA;
    if (ofs_ff == `PMMS_OFS_BANK_SEL)
    begin
      rd_byte = bank_sel_ff;
    end
    else if (ofs_ff == `PMMS_OFS_PAGE_SEL)
    begin
      rd_byte = page_sel_ff;
    end
    else if (wmap[10])
    begin
      rd_byte = mem[wmap[9:0]];
    end
  end

  assign sel_we = (state_ff == pmms_pkg::PMMS_WDATA) && scl_fall && (cnt_ff == 4'h8) &&
                  (ofs_ff == `PMMS_OFS_BANK_SEL || ofs_ff == `PMMS_OFS_PAGE_SEL);
  assign i2c_we = (state_ff == pmms_pkg::PMMS_WDATA) && scl_fall && (cnt_ff == 4'h8) &&
                  !sel_we && wmap[10];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end
    else
    begin
      scl_q_ff <= scl_in;
      sda_q_ff <= sda_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff  <= pmms_pkg::PMMS_IDLE;
      sh_ff     <= 8'h00;
      cnt_ff    <= 4'h0;
      rw_ff     <= 1'b0;
      more_ff   <= 1'b0;
      ofs_ff    <= 8'h00;
      sda_oe_ff <= 1'b0;
    end
    else if (mod_rst || stop_det)
    begin
      state_ff  <= pmms_pkg::PMMS_IDLE;
      sda_oe_ff <= 1'b0;
    end
    else if (start_det)
    begin
      state_ff  <= pmms_pkg::PMMS_ADDR;
      cnt_ff    <= 4'h0;
      sda_oe_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        pmms_pkg::PMMS_ADDR, pmms_pkg::PMMS_OFS, pmms_pkg::PMMS_WDATA:
        begin
          if (scl_rise && cnt_ff != 4'h8)
          begin
            sh_ff  <= {sh_ff[6:0], sda_in};
            cnt_ff <= cnt_ff + 4'h1;
          end
          else if (scl_fall && cnt_ff == 4'h8)
          begin
            sda_oe_ff <= 1'b1;
            cnt_ff    <= 4'h0;
            if (state_ff == pmms_pkg::PMMS_ADDR)
            begin
              if (sh_ff[7:1] == dev_addr_ff)
              begin
                rw_ff    <= sh_ff[0];
                state_ff <= pmms_pkg::PMMS_ADDR_ACK;
              end
              else
              begin
                sda_oe_ff <= 1'b0;
                state_ff  <= pmms_pkg::PMMS_IDLE;
              end
            end
            else if (state_ff == pmms_pkg::PMMS_OFS)
            begin
              ofs_ff   <= sh_ff;
              state_ff <= pmms_pkg::PMMS_OFS_ACK;
            end
            else
            begin
              ofs_ff   <= ofs_ff + 8'h01;
              state_ff <= pmms_pkg::PMMS_WACK;
            end
          end
        end
        pmms_pkg::PMMS_ADDR_ACK, pmms_pkg::PMMS_OFS_ACK, pmms_pkg::PMMS_WACK:
        begin
          if (scl_fall)
          begin
            if (state_ff == pmms_pkg::PMMS_ADDR_ACK && rw_ff)
            begin
              sh_ff     <= rd_byte;
              sda_oe_ff <= ~rd_byte[7];
              ofs_ff    <= ofs_ff + 8'h01;
              state_ff  <= pmms_pkg::PMMS_RDATA;
            end
            else
            begin
              sda_oe_ff <= 1'b0;
              state_ff  <= (state_ff == pmms_pkg::PMMS_ADDR_ACK) ? pmms_pkg::PMMS_OFS : pmms_pkg::PMMS_WDATA;
            end
          end
        end
        pmms_pkg::PMMS_RDATA:
        begin
          if (scl_fall)
          begin
            if (cnt_ff == 4'h7)
            begin
              sda_oe_ff <= 1'b0;
              state_ff  <= pmms_pkg::PMMS_RACK;
            end
            else
            begin
              sh_ff     <= {sh_ff[6:0], 1'b0};
              sda_oe_ff <= ~sh_ff[6];
              cnt_ff    <= cnt_ff + 4'h1;
            end
          end
        end
        pmms_pkg::PMMS_RACK:
        begin
          if (scl_rise)
          begin
            more_ff <= ~sda_in;
          end
          else if (scl_fall)
          begin
            cnt_ff <= 4'h0;
            if (more_ff)
            begin
              sh_ff     <= rd_byte;
              sda_oe_ff <= ~rd_byte[7];
              ofs_ff    <= ofs_ff + 8'h01;
              state_ff  <= pmms_pkg::PMMS_RDATA;
            end
            else
            begin
              state_ff <= pmms_pkg::PMMS_IDLE;
            end
          end
        end
        default:
        begin
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      page_sel_ff <= `PMMS_SEL_RST;
      bank_sel_ff <= `PMMS_SEL_RST;
    end
    else if (mod_rst)
    begin
      page_sel_ff <= `PMMS_SEL_RST;
      bank_sel_ff <= `PMMS_SEL_RST;
    end
    else if (sel_we && ofs_ff == `PMMS_OFS_PAGE_SEL)
    begin
      page_sel_ff <= sh_ff;
    end
    else if (sel_we)
    begin
      bank_sel_ff <= sh_ff;
    end
  end

  // paged pages in array
  // serial writes win the port; a colliding apb write waits one cycle
  always_ff @(posedge pclk)
  begin
    if (i2c_we)
    begin
      mem[wmap[9:0]] <= sh_ff;
    end
    else if (pend_ff)
    begin
      mem[pend_idx_ff] <= pend_data_ff;
    end
  end

  assign apb_acc = psel & penable & pready_ff;
  assign apb_wr  = apb_acc & pwrite & ~pslverr_ff & pstrb[0];

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `PMMS_OFS_STATUS:   rd_mux[`PMMS_EV_W-1:0] = status_ff;
      `PMMS_OFS_MASK:     rd_mux[`PMMS_EV_W-1:0] = mask_ff;
      `PMMS_OFS_STATE:    rd_mux = {8'h00, bank_sel_ff, page_sel_ff, 6'h00, rst_q_ff ^ 1'b1, lowpower_ff};
      `PMMS_OFS_MEM_ADDR: rd_mux[9:0] = mem_addr_ff;
      `PMMS_OFS_MEM_DATA: rd_mux[7:0] = mem[mem_addr_ff];
      `PMMS_OFS_DEV_ADDR: rd_mux[6:0] = dev_addr_ff;
      default:            rd_hit = 1'b0;
    endcase
  end

  // one wait-free access phase: answer is prepared during setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else if (psel && !penable)
    begin
      pready_ff  <= 1'b1;
      pslverr_ff <= ~rd_hit;
      prdata_ff  <= pwrite ? 32'h0000_0000 : rd_mux;
    end
    else
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_ff      <= `PMMS_MASK_RST;
      dev_addr_ff  <= `PMMS_DEV_ADDR_RST;
      mem_addr_ff  <= 10'h000;
      pend_ff      <= 1'b0;
      pend_idx_ff  <= 10'h000;
      pend_data_ff <= 8'h00;
    end
    else
    begin
      if (pend_ff && !i2c_we)
      begin
        pend_ff <= 1'b0;
      end
      if (apb_wr && paddr == `PMMS_OFS_MASK)
      begin
        mask_ff <= pwdata[`PMMS_EV_W-1:0];
      end
      if (apb_wr && paddr == `PMMS_OFS_DEV_ADDR)
      begin
        dev_addr_ff <= pwdata[6:0];
      end
      if (apb_wr && paddr == `PMMS_OFS_MEM_ADDR)
      begin
        mem_addr_ff <= {pstrb[1] ? pwdata[9:8] : mem_addr_ff[9:8], pwdata[7:0]};
      end
      else if (apb_acc && !pslverr_ff && paddr == `PMMS_OFS_MEM_DATA)
      begin
        mem_addr_ff <= mem_addr_ff + 10'h001;
      end
      if (apb_wr && paddr == `PMMS_OFS_MEM_DATA)
      begin
        pend_ff      <= 1'b1;
        pend_idx_ff  <= mem_addr_ff;
        pend_data_ff <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_q_ff    <= 1'b1;
      lowpower_ff <= 1'b0;
    end
    else
    begin
      rst_q_ff    <= module_side_reset_n;
      lowpower_ff <= ~module_side_lowpower_n;
    end
  end

  assign ev_set[`PMMS_EV_LOWPOWER]   = lowpower_ff ^ ~module_side_lowpower_n;
  assign ev_set[`PMMS_EV_HOST_RESET] = rst_q_ff & ~module_side_reset_n;
  assign ev_set[`PMMS_EV_PAGE_SEL]   = sel_we;
  assign ev_set[`PMMS_EV_HOST_WRITE] = i2c_we;
  assign ev_clr = (apb_wr && paddr == `PMMS_OFS_STATUS) ? pwdata[`PMMS_EV_W-1:0] : {`PMMS_EV_W{1'b0}};

  // set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_ff <= {`PMMS_EV_W{1'b0}};
    end
    else
    begin
      status_ff <= (status_ff & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_ff        <= 1'b0;
      line_drive_ff <= 1'b0;
      pulldown_ff   <= 1'b0;
    end
    else
    begin
      irq_ff        <= |(status_ff & mask_ff);
      line_drive_ff <= |(status_ff & mask_ff);
      pulldown_ff   <= 1'b1;
    end
  end

  assign prdata                                  = prdata_ff;
  assign pready                                  = pready_ff;
  assign pslverr                                 = pslverr_ff;
  assign scl_out                                 = 1'b0;
  assign scl_oe                                  = 1'b0;
  assign sda_out                                 = 1'b0;
  assign sda_oe                                  = sda_oe_ff;
  assign irq_reset_combined_line_drive           = line_drive_ff;
  assign lowpower_present_combined_line_pulldown = pulldown_ff;
  assign lowpower_mode                           = lowpower_ff;
  assign module_reset_active                     = ~rst_q_ff;
  assign irq                                     = irq_ff;

endmodule

`default_nettype wire

//--- hw/pmms_defs.svh
`ifndef PMMS_DEFS_SVH
`define PMMS_DEFS_SVH

// apb register byte offsets
`define PMMS_OFS_STATUS      8'h00
`define PMMS_OFS_MASK        8'h04
`define PMMS_OFS_STATE       8'h08
`define PMMS_OFS_MEM_ADDR    8'h0C
`define PMMS_OFS_MEM_DATA    8'h10
`define PMMS_OFS_DEV_ADDR    8'h14

// event bits, shared by status and mask
`define PMMS_EV_W            4
`define PMMS_EV_LOWPOWER     0
`define PMMS_EV_HOST_RESET   1
`define PMMS_EV_PAGE_SEL     2
`define PMMS_EV_HOST_WRITE   3

// state register fields
`define PMMS_ST_LOWPOWER     0
`define PMMS_ST_RESET        1
`define PMMS_ST_PAGE_LSB     8
`define PMMS_ST_BANK_LSB     16

// management space layout
`define PMMS_UPPER_BIT       7
`define PMMS_OFS_BANK_SEL    8'h7E
`define PMMS_OFS_PAGE_SEL    8'h7F
`define PMMS_PAGE_00         8'h00
`define PMMS_PAGE_01         8'h01
`define PMMS_PAGE_02         8'h02
`define PMMS_PAGE_10         8'h10
`define PMMS_PAGE_11         8'h11
`define PMMS_SLOT_LOWER      3'h0
`define PMMS_SLOT_P00        3'h1
`define PMMS_SLOT_P01        3'h2
`define PMMS_SLOT_P02        3'h3
`define PMMS_SLOT_P10_B0     3'h4
`define PMMS_SLOT_P11_B0     3'h5
`define PMMS_SLOT_P10_B1     3'h6
`define PMMS_SLOT_P11_B1     3'h7
`define PMMS_MEM_DEPTH       1024
`define PMMS_UNMAPPED_DATA   8'hFF

// reset values
`define PMMS_DEV_ADDR_RST    7'h50
`define PMMS_SEL_RST         8'h00
`define PMMS_MASK_RST        4'h0

`endif

//--- hw/pmms_pkg.sv
package pmms_pkg;

  typedef enum logic [3:0]
  {
    PMMS_IDLE     = 4'h0,
    PMMS_ADDR     = 4'h1,
    PMMS_ADDR_ACK = 4'h2,
    PMMS_OFS      = 4'h3,
    PMMS_OFS_ACK  = 4'h4,
    PMMS_WDATA    = 4'h5,
    PMMS_WACK     = 4'h6,
    PMMS_RDATA    = 4'h7,
    PMMS_RACK     = 4'h8
  } pmms_state_t;

endpackage

//--- bench/pmms_chk.sv
`timescale 1ns/100ps
`default_nettype none
module pmms_chk
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_in,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic module_side_reset_n,
  input wire logic module_side_lowpower_n,
  input wire logic irq_reset_combined_line_drive,
  input wire logic lowpower_present_combined_line_pulldown,
  input wire logic lowpower_mode,
  input wire logic module_reset_active,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_lowpower_entry: assert property ($fell(module_side_lowpower_n) |=> lowpower_mode)
    else $error("low-power mode not entered");
  chk_lowpower_exit: assert property ($rose(module_side_lowpower_n) |=> !lowpower_mode)
    else $error("low-power mode not left");
  chk_reset_hold: assert property (!module_side_reset_n [*2] |-> module_reset_active)
    else $error("module reset not active");
  chk_present_pd: assert property ($past(presetn) |-> lowpower_present_combined_line_pulldown)
    else $error("presence pull-down missing");
  chk_irq_line: assert property (irq_reset_combined_line_drive == irq)
    else $error("combined line drive differs from irq");
  chk_scl_free: assert property (!scl_oe && !sda_out)
    else $error("serial clock driven or data driven high");
  chk_sda_on_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
    else $error("data changed while serial clock high");
  chk_apb_answer: assert property (psel && !penable |=> pready && penable)
    else $error("register access not answered");
  chk_apb_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_qual: assert property (pslverr |-> pready)
    else $error("error without ready");

  cov_bad_addr: cover property (pready && pslverr);
  cov_irq: cover property ($rose(irq));
  cov_ack: cover property ($rose(sda_oe));
  cov_host_reset: cover property ($fell(module_side_reset_n));
endmodule

bind pmms_top pmms_chk u_chk
(
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .scl_in, .scl_oe, .sda_out, .sda_oe,
  .module_side_reset_n, .module_side_lowpower_n, .irq_reset_combined_line_drive,
  .lowpower_present_combined_line_pulldown, .lowpower_mode, .module_reset_active, .irq
);
`default_nettype wire

//--- bench/pmms_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module pmms_host_model
(
  input  wire logic pclk,
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  input  wire logic pd_in,
  output wire logic scl_line,
  output wire logic sda_line,
  output var  logic reset_n,
  output var  logic lowpower_n,
  output wire logic host_side_present_n
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;

  initial
  begin
    reset_n = 1'b1;
    lowpower_n = 1'b1;
  end

  assign scl_line = !(scl_low || scl_oe);
  assign sda_line = !(sda_low || sda_oe);
  assign host_side_present_n = !pd_in;

  task half;
    repeat (4) @(posedge pclk);
  endtask

  task side(input logic r, input logic l);
    @(posedge pclk);
    reset_n <= r;
    lowpower_n <= l;
  endtask

  // works from idle and as repeated start
  task start;
    half;
    sda_low <= 1'b0;
    half;
    scl_low <= 1'b0;
    half;
    sda_low <= 1'b1;
    half;
    scl_low <= 1'b1;
  endtask

  task stop;
    half;
    sda_low <= 1'b1;
    half;
    scl_low <= 1'b0;
    half;
    sda_low <= 1'b0;
    half;
  endtask

  // data moves only while the clock is low
  task bitx(input logic v, output logic s);
    half;
    sda_low <= !v;
    half;
    scl_low <= 1'b0;
    half;
    s = sda_line;
    scl_low <= 1'b1;
  endtask

  task byte_tx(input logic [7:0] b, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], s);
    bitx(1'b1, s);
    a = !s;
  endtask

  task byte_rx(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'b1, s);
      b[i] = s;
    end
    bitx(1'b1, s);
  endtask

  task xw(input logic [6:0] d, input logic [7:0] o, input logic [7:0] v, output logic ok);
    logic a1;
    logic a2;
    logic a3;
    start;
    byte_tx({d, 1'b0}, a1);
    byte_tx(o, a2);
    byte_tx(v, a3);
    stop;
    ok = a1 && a2 && a3;
  endtask

  task xr(input logic [6:0] d, input logic [7:0] o, output logic [7:0] v, output logic ok);
    logic a1;
    logic a2;
    logic a3;
    start;
    byte_tx({d, 1'b0}, a1);
    byte_tx(o, a2);
    start;
    byte_tx({d, 1'b1}, a3);
    byte_rx(v);
    stop;
    ok = a1 && a2 && a3;
  endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
`include "pmms_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  wire         scl_line, sda_line, scl_oe, sda_oe, rst_n, lp_n, present_n, pd, lp_mode, rst_act, irq, drive;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  got;
  logic        ok;
  logic [6:0]  dev = `PMMS_DEV_ADDR_RST;
  logic [7:0]  pg [7] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h11, 8'h10, 8'h11};
  logic [6:0]  ofs [7];
  logic [7:0]  val [7];
  logic [6:0]  lo;
  logic [7:0]  lov;
  int          errors = 0;
  int          checks = 0;
  int          seed;

  pmms_top dut
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .scl_in(scl_line), .scl_out(), .scl_oe, .sda_in(sda_line), .sda_out(), .sda_oe,
    .module_side_reset_n(rst_n), .module_side_lowpower_n(lp_n), .irq_reset_combined_line_drive(drive),
    .lowpower_present_combined_line_pulldown(pd), .lowpower_mode(lp_mode), .module_reset_active(rst_act), .irq
  );

  pmms_host_model host
  (
    .pclk, .scl_oe, .sda_oe, .pd_in(pd), .scl_line, .sda_line, .reset_n(rst_n), .lowpower_n(lp_n),
    .host_side_present_n(present_n)
  );

  initial
    forever #20 pclk = ~pclk;

  task summarize;
    $display("COUNT errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task cmp_word(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task cmp_bit(input logic g, input logic e, input string m);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("BAD t=%0t %s got %b", $time, m, g);
    end
  endtask

  // waits for ready without assuming latency; only the watchdog ends a hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdw(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task memw(input logic [9:0] i, input logic [7:0] d);
    wr(`PMMS_OFS_MEM_ADDR, {22'h0, i});
    wr(`PMMS_OFS_MEM_DATA, {24'h0, d});
  endtask

  initial
  begin
    repeat (60000) @(posedge pclk);
    errors++;
    $display("BAD t=%0t watchdog", $time);
    summarize;
  end

  initial
  begin
    seed = $urandom(32'h8C05DABA);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdw(`PMMS_OFS_DEV_ADDR);
    cmp_word(rd, 32'h50, "dev addr");
    rdw(`PMMS_OFS_STATE);
    cmp_word(rd, 32'h0, "state");
    cmp_bit(present_n, 1'b0, "present");
    rdw(8'h18);
    cmp_bit(er, 1'b1, "unmapped err");
    cmp_word(rd, 32'h0, "unmapped data");
    pstrb <= 4'h0;
    wr(`PMMS_OFS_MASK, 32'hF);
    pstrb <= 4'hF;
    rdw(`PMMS_OFS_MASK);
    cmp_word(rd, 32'h0, "mask");
    $display("test reset done");

    lo = 7'($urandom_range(125, 0));
    lov = 8'($urandom);
    memw({3'h0, lo}, lov);
    for (int i = 0; i < 7; i++)
    begin
      ofs[i] = 7'($urandom);
      val[i] = 8'($urandom);
      memw({3'(i + 1), ofs[i]}, val[i]);
    end
    for (int i = 0; i < 7; i++)
    begin
      host.xw(dev, `PMMS_OFS_BANK_SEL, {7'h0, i > 4}, ok);
      host.xw(dev, `PMMS_OFS_PAGE_SEL, pg[i], ok);
      host.xr(dev, {1'b1, ofs[i]}, got, ok);
      cmp_bit(ok, 1'b1, "ack");
      cmp_word({24'h0, got}, {24'h0, val[i]}, "page data");
    end
    rdw(`PMMS_OFS_STATE);
    cmp_word(rd, 32'h00011100, "state sel");
    host.xr(dev, {1'b0, lo}, got, ok);
    cmp_word({24'h0, got}, {24'h0, lov}, "lower");
    host.xw(dev, `PMMS_OFS_PAGE_SEL, 8'h03, ok);
    host.xr(dev, {1'b1, ofs[0]}, got, ok);
    cmp_word({24'h0, got}, 32'hFF, "absent");
    host.xw(dev, `PMMS_OFS_BANK_SEL, 8'h02, ok);
    host.xw(dev, `PMMS_OFS_PAGE_SEL, 8'h10, ok);
    host.xr(dev, {1'b1, ofs[3]}, got, ok);
    cmp_word({24'h0, got}, 32'hFF, "absent bank");
    host.xw(dev, `PMMS_OFS_BANK_SEL, 8'h01, ok);
    host.xw(dev, `PMMS_OFS_PAGE_SEL, 8'h11, ok);
    $display("test paging done");

    wr(`PMMS_OFS_STATUS, 32'hF);
    wr(`PMMS_OFS_MASK, 32'h8);
    lov = 8'($urandom);
    host.xw(dev, {1'b1, ofs[6]}, lov, ok);
    repeat (3) @(posedge pclk);
    cmp_bit(irq, 1'b1, "irq set");
    cmp_bit(drive, 1'b1, "line");
    wr(`PMMS_OFS_MEM_ADDR, {22'h0, 3'h7, ofs[6]});
    rdw(`PMMS_OFS_MEM_DATA);
    cmp_word(rd, {24'h0, lov}, "serial write");
    wr(`PMMS_OFS_STATUS, 32'h8);
    repeat (3) @(posedge pclk);
    cmp_bit(irq, 1'b0, "irq clear");
    wr(`PMMS_OFS_MASK, 32'h0);
    host.xw(dev, {1'b1, ofs[6]}, lov, ok);
    repeat (3) @(posedge pclk);
    cmp_bit(irq, 1'b0, "irq masked");
    rdw(`PMMS_OFS_STATUS);
    cmp_word(rd & 32'h8, 32'h8, "sticky");
    $display("test irq done");

    dev = 7'h08 + 7'($urandom_range(63, 0));
    wr(`PMMS_OFS_DEV_ADDR, {25'h0, dev});
    host.xw(`PMMS_DEV_ADDR_RST, {1'b0, lo}, 8'h00, ok);
    cmp_bit(ok, 1'b0, "old addr");
    rdw(`PMMS_OFS_DEV_ADDR);
    cmp_word(rd, {25'h0, dev}, "dev addr new");
    host.xr(dev, {1'b0, lo}, got, ok);
    cmp_bit(ok, 1'b1, "new addr");
    $display("test address done");

    host.side(1'b1, 1'b0);
    repeat (3) @(posedge pclk);
    cmp_bit(lp_mode, 1'b1, "lowpower");
    host.side(1'b1, 1'b1);
    host.side(1'b0, 1'b1);
    repeat (3) @(posedge pclk);
    cmp_bit(rst_act, 1'b1, "reset");
    host.side(1'b1, 1'b1);
    rdw(`PMMS_OFS_STATUS);
    cmp_word(rd & 32'h3, 32'h3, "side events");
    host.xr(dev, {1'b1, ofs[0]}, got, ok);
    cmp_word({24'h0, got}, {24'h0, val[0]}, "page reset");
    $display("test sideband done");

    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdw(`PMMS_OFS_DEV_ADDR);
    cmp_word(rd, 32'h50, "re-reset");
    $display("test rereset done");
    summarize;
  end
endmodule
`default_nettype wire
